// ### core/sac_ctrl.sv
// Added by the designer: the register addresses and the strobed register port.
`default_nettype none
// What this block does
// - Free-run loops integrate, convert, hold; it waits in hold while a read of the bank about to be written runs
// - Readout clears pixel charge, restarting accumulation
// - Readout finishes before next integration starts
// - Free-run overwrites held line every conversion
// - Request returns currently held line immediately
// - Trigger-hold keeps line integrated after edge
// - Trigger-hold discards held line once read
// - New trigger edge replaces unread held line
// - Labelling marks lines integrated at active level
// - Label travels with the line data
module sac_ctrl
    import sac_pkg::*;
#(
    parameter int PIXELS = 16
) (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    input  wire logic [sac_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [sac_pkg::BUS_W-1:0]   i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [sac_pkg::BUS_W-1:0]   o_rdata,
    input  wire logic                        i_trigger,
    output logic                             o_integ,
    output logic                             o_conv_start,
    output logic      [$clog2(PIXELS)-1:0]   o_pix_addr,
    input  wire logic                        i_adc_valid,
    input  wire logic [sac_pkg::PIX_W-1:0]   i_adc_data,
    output sac_pkg::sac_word_type            o_word,
    output logic                             o_word_valid,
    input  wire logic                        i_word_ready
);
    import sac_pkg::*;
    localparam int PA_W = $clog2(PIXELS);
    if (PIXELS < 2) begin : g_chk
        $error("sac_ctrl needs at least two pixels");
    end

    // ****************************************************
    // Declarations
    // ****************************************************
    typedef enum logic [1:0] {S_INTEG, S_READ, S_WAIT, S_HOLD} sac_state_type;
    sac_state_type       state_reg;
    sac_state_type       state_next;
    logic [31:0]         ctrl_reg;
    logic [31:0]         itime_reg;
    logic [31:0]         icount_reg;
    logic [1:0]          mode_reg;
    logic                edge_sel_reg;
    logic                level_sel_reg;
    logic [PA_W-1:0]     pix_reg;
    logic [PIX_W-1:0]    line_mem [2][PIXELS];
    logic [1:0]          label_mem;
    logic                held_bank_reg;
    logic                held_valid_reg;
    logic                label_acc_reg;
    logic                pending_reg;
    logic                armed_reg;
    logic                trig_sync;
    logic                trig_prev_reg;
    logic                trig_edge;
    logic                trig_active;
    logic                integ_start;
    logic                conv_done;
    logic                flip;
    logic                xfer_busy_reg;
    logic                xfer_none_reg;
    logic                xfer_bank_reg;
    logic [PA_W-1:0]     xfer_idx_reg;
    logic                req_go;
    logic                buf_ready;
    logic                push;
    logic                xfer_end;
    sac_word_type        push_word;

    function automatic logic is_last(input logic [PA_W-1:0] idx);
        return idx == PA_W'(PIXELS - 1);
    endfunction

    // ****************************************************
    // Trigger conditioning
    // ****************************************************
    sac_sync #(
        .STAGES (2)
    ) u_trig_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_trigger),
        .o_sync  (trig_sync)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_sync;
        end
    end

    assign trig_edge   = edge_sel_reg ? (trig_sync && !trig_prev_reg)
                                      : (!trig_sync && trig_prev_reg);
    assign trig_active = (trig_sync == level_sel_reg);

    // ****************************************************
    // Register port
    // ****************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg  <= CTRL_RST;
            itime_reg <= ITIME_RST;
        end else if (i_wr && i_addr == CTRL_OFFSET) begin
            ctrl_reg  <= {28'h000_0000, i_wdata[3:0]};
        end else if (i_wr && i_addr == ITIME_OFFSET) begin
            // Zero would make an empty integration; hold at one cycle
            itime_reg <= (i_wdata == 32'h0000_0000) ? 32'h0000_0001 : i_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                CTRL_OFFSET:   o_rdata <= ctrl_reg;
                ITIME_OFFSET:  o_rdata <= itime_reg;
                STATUS_OFFSET: o_rdata <= {26'h000_0000, mode_reg,
                                           o_integ, xfer_busy_reg,
                                           label_mem[held_bank_reg], held_valid_reg};
                default:       o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // ****************************************************
    // Acquisition sequence
    // ****************************************************
    assign integ_start = (state_reg == S_HOLD) && (state_next == S_INTEG);
    assign conv_done   = (state_reg == S_WAIT) && i_adc_valid && is_last(pix_reg);
    assign flip        = conv_done && (mode_reg != MODE_HOLD || armed_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_INTEG: begin
                if (icount_reg >= itime_reg) begin
                    state_next = S_READ;
                end
            end
            S_READ: begin
                state_next = S_WAIT;
            end
            S_WAIT: begin
                if (i_adc_valid) begin
                    state_next = is_last(pix_reg) ? S_HOLD : S_READ;
                end
            end
            S_HOLD: begin
                // A slow reader of the bank about to be written stalls the loop
                if (!(xfer_busy_reg && xfer_bank_reg == !held_bank_reg)) begin
                    state_next = S_INTEG;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= S_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_integ      <= 1'b0;
            o_conv_start <= 1'b0;
        end else begin
            o_integ      <= (state_next == S_INTEG);
            o_conv_start <= (state_next == S_READ);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            icount_reg <= '0;
        end else if (state_reg == S_INTEG) begin
            icount_reg <= icount_reg + 32'h0000_0001;
        end else begin
            icount_reg <= 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pix_reg    <= '0;
            o_pix_addr <= '0;
        end else if (state_reg == S_WAIT && i_adc_valid) begin
            pix_reg    <= is_last(pix_reg) ? '0 : pix_reg + PA_W'(1);
            o_pix_addr <= is_last(pix_reg) ? '0 : pix_reg + PA_W'(1);
        end
    end

    // Conversions fill the bank that is not held
    always_ff @(posedge i_clock) begin
        if (state_reg == S_WAIT && i_adc_valid) begin
            line_mem[!held_bank_reg][pix_reg] <= i_adc_data;
        end
    end

    // ****************************************************
    // Mode latching and trigger capture
    // ****************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg      <= CTRL_RST[MODE_LSB +: 2];
            edge_sel_reg  <= CTRL_RST[EDGE_BIT];
            level_sel_reg <= CTRL_RST[LEVEL_BIT];
        end else if (integ_start) begin
            mode_reg      <= ctrl_reg[MODE_LSB +: 2];
            edge_sel_reg  <= ctrl_reg[EDGE_BIT];
            level_sel_reg <= ctrl_reg[LEVEL_BIT];
        end
    end

    // An edge seen during an integration arms the one after it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_reg <= 1'b0;
            armed_reg   <= 1'b0;
        end else begin
            pending_reg <= trig_edge || (pending_reg && !integ_start);
            if (integ_start) begin
                armed_reg <= pending_reg;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            label_acc_reg <= 1'b0;
        end else if (integ_start) begin
            label_acc_reg <= 1'b0;
        end else if (state_reg == S_INTEG && trig_active) begin
            label_acc_reg <= 1'b1;
        end
    end

    // ****************************************************
    // Held line
    // ****************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held_bank_reg  <= 1'b0;
            held_valid_reg <= 1'b0;
            label_mem      <= 2'b00;
        end else begin
            if (flip) begin
                held_bank_reg               <= !held_bank_reg;
                label_mem[!held_bank_reg]   <= (mode_reg == MODE_LABEL) && label_acc_reg;
            end
            // New capture wins over a discard in the same cycle
            if (flip) begin
                held_valid_reg <= 1'b1;
            end else if (xfer_end && mode_reg == MODE_HOLD) begin
                held_valid_reg <= 1'b0;
            end else if (integ_start && ctrl_reg[MODE_LSB +: 2] == MODE_HOLD
                         && mode_reg != MODE_HOLD) begin
                held_valid_reg <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Data request and transfer
    // ****************************************************
    assign req_go    = i_wr && i_addr == REQ_OFFSET && !xfer_busy_reg;
    assign push      = xfer_busy_reg && buf_ready;
    assign xfer_end  = push && (xfer_none_reg || is_last(xfer_idx_reg));
    assign push_word = '{none:  xfer_none_reg,
                         label: label_mem[xfer_bank_reg],
                         last:  xfer_none_reg || is_last(xfer_idx_reg),
                         pixel: xfer_none_reg ? '0 : line_mem[xfer_bank_reg][xfer_idx_reg]};

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xfer_busy_reg <= 1'b0;
            xfer_none_reg <= 1'b0;
            xfer_bank_reg <= 1'b0;
            xfer_idx_reg  <= '0;
        end else if (req_go) begin
            xfer_busy_reg <= 1'b1;
            xfer_none_reg <= !held_valid_reg;
            xfer_bank_reg <= held_bank_reg;
            xfer_idx_reg  <= '0;
        end else if (xfer_end) begin
            xfer_busy_reg <= 1'b0;
        end else if (push) begin
            xfer_idx_reg  <= xfer_idx_reg + PA_W'(1);
        end
    end

    sac_buf #(
        .W ($bits(sac_word_type))
    ) u_buf (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_data  (push_word),
        .i_valid (xfer_busy_reg),
        .o_ready (buf_ready),
        .o_data  (o_word),
        .o_valid (o_word_valid),
        .i_ready (i_word_ready)
    );

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence last_conversion;
        (state_reg == S_WAIT) && i_adc_valid && is_last(pix_reg);
    endsequence

    phase_excl_a: assert property (!(o_integ && o_conv_start))
        else $error("integration and conversion overlap");
    read_follow_a: assert property ($fell(o_integ) |-> o_conv_start)
        else $error("readout did not follow integration");
    integ_after_read_a: assert property ($rose(o_integ) |-> $past(state_reg) == S_HOLD)
        else $error("integration began before readout ended");
    free_update_a: assert property (last_conversion and mode_reg == MODE_FREE
        |=> held_bank_reg != $past(held_bank_reg) && held_valid_reg)
        else $error("free-run line not updated");
    req_answer_a: assert property (req_go |=> xfer_busy_reg
        && xfer_bank_reg == $past(held_bank_reg) && xfer_none_reg == !$past(held_valid_reg))
        else $error("request did not take held line");
    hold_keep_a: assert property (last_conversion and mode_reg == MODE_HOLD && !armed_reg
        |=> held_bank_reg == $past(held_bank_reg))
        else $error("untriggered line was held");
    discard_a: assert property (xfer_end && mode_reg == MODE_HOLD && !flip
        |=> !held_valid_reg)
        else $error("read line not discarded");
    replace_a: assert property (last_conversion and mode_reg == MODE_HOLD && armed_reg
        |=> held_valid_reg && held_bank_reg != $past(held_bank_reg))
        else $error("triggered line not taken");
    label_mark_a: assert property (state_reg == S_INTEG && !integ_start
        && trig_active |=> label_acc_reg)
        else $error("active level not marked");
    label_send_a: assert property (push && !xfer_end
        |=> push_word.label == $past(push_word.label))
        else $error("label changed within line");
    mode_stable_a: assert property (state_reg != S_HOLD |=> $stable(mode_reg))
        else $error("mode changed mid-cycle");
endmodule
`default_nettype wire

// ### core/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // ****************************************************
    // Register port
    // ****************************************************
    localparam int          ADDR_W         = 4;
    localparam int          BUS_W          = 32;
    localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
    localparam logic [3:0]  ITIME_OFFSET   = 4'h4;
    localparam logic [3:0]  REQ_OFFSET     = 4'h8;
    localparam logic [3:0]  STATUS_OFFSET  = 4'hc;
    // ****************************************************
    // Control fields and reset values
    // ****************************************************
    localparam int          MODE_LSB       = 0;
    localparam int          EDGE_BIT       = 2;
    localparam int          LEVEL_BIT      = 3;
    localparam int          STAT_HELD_BIT  = 0;
    localparam int          STAT_LABEL_BIT = 1;
    localparam int          STAT_XFER_BIT  = 2;
    localparam int          STAT_INTEG_BIT = 3;
    localparam int          STAT_MODE_LSB  = 4;
    localparam logic [1:0]  MODE_FREE      = 2'h0;
    localparam logic [1:0]  MODE_HOLD      = 2'h1;
    localparam logic [1:0]  MODE_LABEL     = 2'h2;
    localparam logic [31:0] CTRL_RST       = 32'h0000_000c;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          INTEG_TIME_NS  = 1000;
    localparam int          INTEG_CYCLES   = (INTEG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] ITIME_RST      = 32'(INTEG_CYCLES);
    // ****************************************************
    // Stream word
    // ****************************************************
    localparam int          PIX_W          = 16;
    typedef struct packed {
        logic              none;
        logic              label;
        logic              last;
        logic [PIX_W-1:0]  pixel;
    } sac_word_type;
endpackage
`default_nettype wire

// ### core/sac_sync.sv
`default_nettype none
module sac_sync #(
    parameter int STAGES = 2
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    import sac_pkg::*;
    if (STAGES < 2) begin : g_chk
        $error("sac_sync needs at least two stages");
    end
    logic [STAGES-1:0] chain_reg;
    // Only the last stage is read; the first may be metastable
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], i_async};
        end
    end
    assign o_sync = chain_reg[STAGES-1];
endmodule
`default_nettype wire

// ### core/sac_buf.sv
`default_nettype none
module sac_buf #(
    parameter int W = 19
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    output logic [W-1:0]      o_data,
    output logic              o_valid,
    input  wire logic         i_ready
);
    import sac_pkg::*;
    if (W < 1) begin : g_chk
        $error("sac_buf width must be positive");
    end
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic         head_v_reg;
    logic         tail_v_reg;
    logic         push;
    logic         pop;
    // Second entry absorbs the word in flight when the receiver stalls
    assign o_ready = !tail_v_reg;
    assign push    = i_valid && !tail_v_reg;
    assign pop     = head_v_reg && i_ready;
    assign o_data  = head_reg;
    assign o_valid = head_v_reg;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            head_reg   <= '0;
            tail_reg   <= '0;
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
        end else if (push && (pop || !head_v_reg)) begin
            head_reg   <= i_data;
            head_v_reg <= 1'b1;
        end else if (push) begin
            tail_reg   <= i_data;
            tail_v_reg <= 1'b1;
        end else if (pop) begin
            head_reg   <= tail_reg;
            head_v_reg <= tail_v_reg;
            tail_v_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### dv/sac_adc_model.sv
`default_nettype none
// ****************************************************
// Sensor and converter stand-in
// ****************************************************
module sac_adc_model #(
    parameter int PA_W = 2
) (
    input  wire logic            i_clock,
    input  wire logic            i_rst_n,
    input  wire logic            i_integ,
    input  wire logic            i_conv_start,
    input  wire logic [PA_W-1:0] i_pix_addr,
    output logic                 o_adc_valid,
    output logic      [15:0]     o_adc_data,
    output logic      [7:0]      o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic integ_q;
    int   wait_cnt;
    // Each line number rides in the upper byte, so a stale line is never mistaken for a new one
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            integ_q     <= 1'b0;
            wait_cnt    <= 0;
            o_adc_valid <= 1'b0;
            o_adc_data  <= 16'h0;
            o_line      <= 8'h0;
        end else begin
            integ_q     <= i_integ;
            o_adc_valid <= 1'b0;
            if (i_integ && !integ_q) begin
                o_line <= o_line + 8'h1;
            end
            if (i_conv_start) begin
                wait_cnt   <= 1 + int'($urandom % 4);
                o_adc_data <= ~o_adc_data;
            end else if (wait_cnt > 1) begin
                wait_cnt   <= wait_cnt - 1;
                o_adc_data <= ~o_adc_data;
            end else if (wait_cnt == 1) begin
                wait_cnt    <= 0;
                o_adc_valid <= 1'b1;
                o_adc_data  <= {o_line, 8'(i_pix_addr)};
            end else begin
                // Released data lines toggle so a late sample shows up as wrong
                o_adc_data <= ~o_adc_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/sac_ctrl_bench.sv
`default_nettype none
module sac_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    localparam int PIXELS = 4;
    logic         i_clock;
    logic         i_rst_n;
    logic [3:0]   i_addr;
    logic [31:0]  i_wdata;
    logic         i_wr;
    logic         i_rd;
    logic [31:0]  o_rdata;
    logic         i_trigger;
    logic         o_integ;
    logic         o_conv_start;
    logic [1:0]   o_pix_addr;
    logic         adc_valid;
    logic [15:0]  adc_data;
    sac_word_type o_word;
    logic         o_word_valid;
    logic         i_word_ready;
    logic [7:0]   line;
    logic [7:0]   k;
    logic [31:0]  d;
    int           mismatches;
    int           tests_run;
    sac_ctrl #(.PIXELS(PIXELS)) i_sac_ctrl (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trigger(i_trigger),
        .o_integ(o_integ), .o_conv_start(o_conv_start), .o_pix_addr(o_pix_addr),
        .i_adc_valid(adc_valid), .i_adc_data(adc_data), .o_word(o_word),
        .o_word_valid(o_word_valid), .i_word_ready(i_word_ready));
    sac_adc_model #(.PA_W(2)) i_sac_adc_model (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_integ(o_integ),
        .i_conv_start(o_conv_start), .i_pix_addr(o_pix_addr),
        .o_adc_valid(adc_valid), .o_adc_data(adc_data), .o_line(line));
    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        @(negedge i_clock);
        v = o_rdata;
    endtask
    task automatic wait_lines(input int n);
        logic [7:0] t;
        t = line + 8'(n);
        for (int i = 0; i < 3000; i++) begin
            @(negedge i_clock);
            if (line == t) return;
        end
        mismatches++;
        complete_run();
    endtask
    // Edge lands a few cycles into integration k, so line k+1 is the armed one
    task automatic arm(input logic act, output logic [7:0] kk);
        wait_lines(1);
        kk = line;
        @(posedge i_clock);
        i_trigger <= ~act;
        repeat (3) @(posedge i_clock);
        i_trigger <= act;
    endtask
    task automatic get(input logic nn, input logic [7:0] ln, input logic lab);
        int           got;
        logic         fin;
        sac_word_type w;
        got = 0;
        fin = 1'b0;
        wr(REQ_OFFSET, $urandom);
        for (int i = 0; i < 2000 && !fin; i++) begin
            @(negedge i_clock);
            if (o_word_valid === 1'b1 && i_word_ready === 1'b1) begin
                w = o_word;
                check(32'(w.none), 32'(nn));
                check(32'(w.last), 32'(nn || got == PIXELS - 1));
                check(32'(w.pixel), nn ? 32'h0 : {16'h0, ln, 8'(got)});
                if (!nn) check(32'(w.label), 32'(lab));
                got++;
                fin = w.last;
            end
            @(posedge i_clock);
            i_word_ready <= 1'($urandom % 3 != 0);
        end
        if (!fin) begin
            mismatches++;
            complete_run();
        end
        check(got, nn ? 1 : PIXELS);
    endtask
    // ****************************************************
    // Clock and phase monitor
    // ****************************************************
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(negedge i_clock) begin
        if (i_rst_n && o_conv_start === 1'b1) check(32'(o_integ), 32'h0);
    end
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        i_rst_n = 1'b0;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_trigger = 1'b0;
        i_word_ready = 1'b1;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(32'h3b5f));
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(CTRL_OFFSET, d);
        check(d, CTRL_RST);
        rd(ITIME_OFFSET, d);
        check(d, ITIME_RST);
        rd(4'h1, d);
        check(d, 32'h0);
        wr(ITIME_OFFSET, 32'h0);
        rd(ITIME_OFFSET, d);
        check(d, 32'h1);
        wr(ITIME_OFFSET, 32'h8);
        get(1'b1, 8'h0, 1'b0);
        repeat (4) begin
            wait_lines(1 + int'($urandom % 2));
            get(1'b0, line - 8'h1, 1'b0);
        end
        for (int e = 1; e >= 0; e--) begin
            @(posedge i_clock);
            i_trigger <= ~e[0];
            wr(CTRL_OFFSET, {28'h0, 1'b1, e[0], MODE_HOLD});
            wait_lines(2);
            rd(STATUS_OFFSET, d);
            check(32'(d[5:4]), 32'(MODE_HOLD));
            check(32'(d[STAT_HELD_BIT]), 32'h0);
            get(1'b1, 8'h0, 1'b0);
            arm(e[0], k);
            wait_lines(3);
            get(1'b0, k + 8'h1, 1'b0);
            get(1'b1, 8'h0, 1'b0);
            arm(e[0], k);
            wait_lines(2);
            arm(e[0], k);
            wait_lines(3);
            get(1'b0, k + 8'h1, 1'b0);
        end
        for (int lv = 1; lv >= 0; lv--) begin
            wr(CTRL_OFFSET, {28'h0, lv[0], 1'b1, MODE_LABEL});
            for (int a = 1; a >= 0; a--) begin
                i_trigger <= (a == 1) ? lv[0] : ~lv[0];
                wait_lines(3);
                get(1'b0, line - 8'h1, a[0]);
            end
            rd(STATUS_OFFSET, d);
            check(32'(d[5:4]), 32'(MODE_LABEL));
            check(32'(d[STAT_HELD_BIT]), 32'h1);
            check(32'(d[STAT_LABEL_BIT]), 32'h0);
        end
        complete_run();
    end
endmodule
`default_nettype wire
